// *** hw/dsp_compute_datapath.sv ***
// Function
// (RULE1) eight 32-bit multiported registers are source and destination of compute
// (RULE2) the same file is addressable as sixteen 16-bit halves
// (RULE3) operands come only from the register file or instruction constants; ALU_SAT, ALU_RND and the shifter with from_acc read the accumulators
// (RULE4) units handle 8, 16 and 32-bit operand data
// (RULE5) two MACs, two 40-bit ALUs, four video lanes, one 40-bit shifter
// (RULE6) each MAC takes a 16x16 multiply every cycle into a 40-bit accumulator
// (RULE7) MACs support signed, unsigned, rounding and saturation options
// (RULE8) ALUs do arithmetic and logic on 16 or 32-bit operands
// (RULE9) ALUs add extract, popcount, mod 2^32 multiply, divide step, sat, round, sign bits
// (RULE10) video ops: align, pack, clipped adds, 8-bit average, subtract-absolute-accumulate
// (RULE11) compare-select and vector search are dedicated operations
// (RULE12) one ALU can do two independent 16-bit ops on register halves
// (RULE13) both ALUs in dual mode complete four 16-bit ops per cycle
// (RULE14) shifter does shifts, rotates, normalize, field extract and deposit
// (RULE15) full interlock: dependent instructions stall, no visible hazards
// (RULE16) one cycle accepts a multifunction op plus two 16-bit load slots
// (RULE17) saturated overflow clamps to largest positive or most negative value
`timescale 1ns/1ns
`include "dsp_compute_regs.svh"

module dsp_compute_datapath (
	input  wire logic                     mclk_in,
	input  wire logic                     rst_b_in,
	input  wire logic                     issue_valid_in,
	input  wire dsp_compute_pkg::issue_s  issue_in,
	input  wire logic [2:0]               rd_idx_in,
	output logic                          issue_ready_out,
	output logic [31:0]                   rd_data_out,
	output logic [39:0]                   acc0_out,
	output logic [39:0]                   acc1_out,
	output logic [1:0]                    cc_out
);

	dsp_compute_pkg::state_s st_q;
	dsp_compute_pkg::state_s st_d;
	logic                    fire;
	logic [7:0]              pend;
	logic [7:0]              uses;
	logic                    acc_hz;
	logic [31:0]             va;
	logic [31:0]             vb;
	logic [31:0]             vid;
	logic [3:0][7:0]         v_add;
	logic [3:0][7:0]         v_avg;
	logic [3:0][7:0]         v_abs;
	dsp_compute_pkg::wr_s    w0;
	dsp_compute_pkg::wr_s    w1;
	logic [39:0]             s40;
	logic [39:0]             sh_res;

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [15:0] hget(input dsp_compute_pkg::rf_t rf, input logic [3:0] h);
		hget = h[0] ? rf[h[3:1]][31:16] : rf[h[3:1]][15:0]; // [RULE2]
	endfunction

	function automatic logic [15:0] sat16(input logic [16:0] v);
		sat16 = (v[16] != v[15]) ? (v[16] ? `SAT16_NEG : `SAT16_POS) : v[15:0]; // [RULE17]
	endfunction

	function automatic logic [31:0] sat32(input logic [39:0] v);
		sat32 = (v[39:31] == {9{v[39]}}) ? v[31:0] : (v[39] ? `SAT32_NEG : `SAT32_POS); // [RULE17]
	endfunction

	function automatic logic [31:0] sbits(input logic [31:0] a);
		logic       done;
		logic [5:0] n;
		done = 1'b0;
		n = 6'h00;
		for (int i = 30; i >= 0; i--) begin
			if (!done && a[i] == a[31]) n = n + 6'h01;
			else done = 1'b1;
		end
		sbits = {26'h0, n};
	endfunction

	function automatic logic [15:0] lane16(input dsp_compute_pkg::alu_op_e op, input logic [15:0] a,
		input logic [15:0] b, input logic sat);
		logic [16:0] s;
		logic [16:0] d;
		s = {a[15], a} + {b[15], b};
		d = {a[15], a} - {b[15], b};
		case (op)
			dsp_compute_pkg::ALU_ADD:     lane16 = sat ? sat16(s) : s[15:0]; // [RULE8] [RULE17]
			dsp_compute_pkg::ALU_SUB:     lane16 = sat ? sat16(d) : d[15:0];
			dsp_compute_pkg::ALU_AND:     lane16 = a & b;
			dsp_compute_pkg::ALU_OR:      lane16 = a | b;
			dsp_compute_pkg::ALU_XOR:     lane16 = a ^ b;
			dsp_compute_pkg::ALU_NOT:     lane16 = ~a;
			dsp_compute_pkg::ALU_MIN:     lane16 = ($signed(a) < $signed(b)) ? a : b; // [RULE11]
			dsp_compute_pkg::ALU_MAX,
			dsp_compute_pkg::ALU_VSEARCH: lane16 = ($signed(b) > $signed(a)) ? b : a; // [RULE11]
			dsp_compute_pkg::ALU_ADD16C:  lane16 = s[16] ? 16'h0000 : ((s[15:0] > `PIX_MAX) ? `PIX_MAX : s[15:0]);
			default:                      lane16 = a;
		endcase
	endfunction

	function automatic logic [31:0] alu32(input dsp_compute_pkg::alu_op_e op, input logic [31:0] a,
		input logic [31:0] b, input logic sat, input logic [39:0] acc);
		logic [39:0] s;
		logic [39:0] d;
		logic [39:0] r;
		logic [31:0] q;
		s = {{8{a[31]}}, a} + {{8{b[31]}}, b};
		d = {{8{a[31]}}, a} - {{8{b[31]}}, b};
		r = acc + `RND_BIAS;
		q = {a[30:0], 1'b0};
		case (op)
			dsp_compute_pkg::ALU_ADD:      alu32 = sat ? sat32(s) : s[31:0]; // [RULE8] [RULE17]
			dsp_compute_pkg::ALU_SUB:      alu32 = sat ? sat32(d) : d[31:0];
			dsp_compute_pkg::ALU_AND:      alu32 = a & b;
			dsp_compute_pkg::ALU_OR:       alu32 = a | b;
			dsp_compute_pkg::ALU_XOR:      alu32 = a ^ b;
			dsp_compute_pkg::ALU_NOT:      alu32 = ~a;
			dsp_compute_pkg::ALU_MIN:      alu32 = ($signed(a) < $signed(b)) ? a : b; // [RULE11]
			dsp_compute_pkg::ALU_MAX,
			dsp_compute_pkg::ALU_VSEARCH:  alu32 = ($signed(b) > $signed(a)) ? b : a;
			dsp_compute_pkg::ALU_EXTRACT:  alu32 = (a >> b[12:8]) & ~(32'hffff_ffff << b[4:0]); // [RULE9]
			dsp_compute_pkg::ALU_POPCNT:   alu32 = 32'($countones(a)); // [RULE9]
			dsp_compute_pkg::ALU_MUL32:    alu32 = 32'(a * b); // [RULE9]
			// one restoring step: divisor in b low half, partial remainder in a high half
			dsp_compute_pkg::ALU_DIVQ:     alu32 = (q[31:16] >= b[15:0]) ? {q[31:16] - b[15:0], q[15:1], 1'b1} : q;
			dsp_compute_pkg::ALU_SAT:      alu32 = sat32(acc); // [RULE9]
			dsp_compute_pkg::ALU_RND:      alu32 = {{16{r[39]}}, (r[39:31] == {9{r[39]}}) ? r[31:16]
				: (r[39] ? `SAT16_NEG : `SAT16_POS)};
			dsp_compute_pkg::ALU_SIGNBITS: alu32 = sbits(a); // [RULE9]
			default:                       alu32 = a;
		endcase
	endfunction

	function automatic dsp_compute_pkg::wr_s alu_slot(input dsp_compute_pkg::alu_s o,
		input dsp_compute_pkg::rf_t rf, input logic [1:0][39:0] acc, input logic [31:0] v);
		logic [31:0] a;
		logic [31:0] b;
		logic [15:0] bh;
		a = rf[o.a[3:1]];
		b = o.use_imm ? {{16{o.imm[15]}}, o.imm} : rf[o.b[3:1]]; // [RULE3]
		bh = o.use_imm ? o.imm : b[31:16];
		alu_slot.idx = o.dst[3:1];
		alu_slot.mask = 2'b11;
		alu_slot.val = 32'h0;
		if (o.op == dsp_compute_pkg::ALU_NOP) begin
			alu_slot.mask = 2'b00;
		end else if (o.op >= dsp_compute_pkg::ALU_ALIGN) begin
			alu_slot.val = v;
		end else if (o.width == dsp_compute_pkg::W16) begin
			alu_slot.mask = o.dst[0] ? 2'b10 : 2'b01; // [RULE2]
			alu_slot.val = {2{lane16(o.op, hget(rf, o.a), o.use_imm ? o.imm : hget(rf, o.b), o.sat)}};
		end else if (o.width == dsp_compute_pkg::DUAL) begin
			alu_slot.val = {lane16(o.op, a[31:16], bh, o.sat), lane16(o.op, a[15:0], b[15:0], o.sat)}; // [RULE12]
		end else begin
			alu_slot.val = alu32(o.op, a, b, o.sat, acc[o.a[0]]);
		end
	endfunction

	// ---------------------------------------------
	// video lanes, fed by the first ALU's operands
	// ---------------------------------------------
	assign va = st_q.rf[issue_in.alu[0].a[3:1]];
	assign vb = st_q.rf[issue_in.alu[0].b[3:1]];

	for (genvar g = 0; g < 4; g++) begin : g_vid
		logic [8:0] s9;
		logic [9:0] s10;
		assign s9 = {1'b0, va[8*g+:8]} + {1'b0, vb[8*g+:8]};
		assign s10 = {1'b0, s9} + 10'h001;
		assign v_add[g] = s9[8] ? 8'hff : s9[7:0]; // [RULE10] [RULE4]
		assign v_avg[g] = s10[8:1];
		assign v_abs[g] = (va[8*g+:8] > vb[8*g+:8]) ? va[8*g+:8] - vb[8*g+:8] : vb[8*g+:8] - va[8*g+:8];
	end

	always_comb begin
		logic [63:0] cat;
		cat = {va, vb} >> {issue_in.alu[0].imm[1:0], 3'b000};
		case (issue_in.alu[0].op) // [RULE10]
			dsp_compute_pkg::ALU_ALIGN:  vid = cat[31:0];
			dsp_compute_pkg::ALU_PACK:   vid = {va[23:16], va[7:0], vb[23:16], vb[7:0]};
			dsp_compute_pkg::ALU_ADD16C: vid = {lane16(dsp_compute_pkg::ALU_ADD16C, va[31:16], vb[31:16], 1'b0),
				lane16(dsp_compute_pkg::ALU_ADD16C, va[15:0], vb[15:0], 1'b0)};
			dsp_compute_pkg::ALU_ADD8C:  vid = v_add;
			dsp_compute_pkg::ALU_AVG8:   vid = v_avg;
			dsp_compute_pkg::ALU_SUBTRACT_ABSOLUTE_ACCUMULATE:
				vid = st_q.rf[issue_in.alu[0].dst[3:1]] + {24'h0, v_abs[0]} + {24'h0, v_abs[1]}
					+ {24'h0, v_abs[2]} + {24'h0, v_abs[3]};
			default:                     vid = 32'h0;
		endcase
	end

	// ---------------------------------------------
	// interlock
	// ---------------------------------------------
	always_comb begin
		pend = 8'h00;
		uses = 8'h00;
		acc_hz = 1'b0;
		for (int m = 0; m < 2; m++) begin
			if (st_q.stg[m].op != dsp_compute_pkg::MAC_NONE && st_q.stg[m].wr) pend[st_q.stg[m].dst[3:1]] = 1'b1;
			if (issue_in.mac[m].op != dsp_compute_pkg::MAC_NONE) begin
				uses[issue_in.mac[m].a[3:1]] = 1'b1;
				uses[issue_in.mac[m].b[3:1]] = 1'b1;
				if (issue_in.mac[m].wr) uses[issue_in.mac[m].dst[3:1]] = 1'b1;
			end
			if (issue_in.alu[m].op != dsp_compute_pkg::ALU_NOP) begin
				uses[issue_in.alu[m].a[3:1]] = 1'b1;
				uses[issue_in.alu[m].dst[3:1]] = 1'b1;
				if (!issue_in.alu[m].use_imm) uses[issue_in.alu[m].b[3:1]] = 1'b1;
			end
			// accumulator readers wait for an in-flight accumulate to land
			if ((issue_in.alu[m].op == dsp_compute_pkg::ALU_SAT || issue_in.alu[m].op == dsp_compute_pkg::ALU_RND)
				&& st_q.stg[issue_in.alu[m].a[0]].op != dsp_compute_pkg::MAC_NONE) acc_hz = 1'b1;
			if (issue_in.ld[m].en) uses[issue_in.ld[m].dst[3:1]] = 1'b1;
		end
		if (issue_in.sh.op != dsp_compute_pkg::SH_NONE) begin
			uses[issue_in.sh.src] = 1'b1;
			uses[issue_in.sh.dst] = 1'b1;
			if (issue_in.sh.from_acc && st_q.stg[0].op != dsp_compute_pkg::MAC_NONE) acc_hz = 1'b1;
		end
	end

	assign issue_ready_out = !((|(pend & uses)) || acc_hz); // [RULE15]
	assign fire = issue_valid_in && issue_ready_out; // [RULE16]

	// ---------------------------------------------
	// shifter
	// ---------------------------------------------
	always_comb begin
		logic [31:0] r;
		logic [31:0] m32;
		r = st_q.rf[issue_in.sh.src];
		s40 = issue_in.sh.from_acc ? st_q.acc[0] : {{8{r[31]}}, r};
		m32 = ~(32'hffff_ffff << issue_in.sh.len) << issue_in.sh.amt;
		case (issue_in.sh.op) // [RULE14]
			dsp_compute_pkg::SH_LSL:  sh_res = s40 << issue_in.sh.amt;
			dsp_compute_pkg::SH_ASR:  sh_res = $signed(s40) >>> issue_in.sh.amt;
			dsp_compute_pkg::SH_LSR:  sh_res = s40 >> issue_in.sh.amt;
			dsp_compute_pkg::SH_ROT:  sh_res = (s40 << issue_in.sh.amt) | (s40 >> (7'd40 - {1'b0, issue_in.sh.amt}));
			dsp_compute_pkg::SH_NORM: sh_res = {8'h00, sbits(r)};
			dsp_compute_pkg::SH_FEXT: sh_res = (s40 >> issue_in.sh.amt) & ~(40'hff_ffff_ffff << issue_in.sh.len);
			dsp_compute_pkg::SH_FDEP: sh_res = {8'h00, (st_q.rf[issue_in.sh.dst] & ~m32)
				| ((r << issue_in.sh.amt) & m32)};
			default:                  sh_res = s40;
		endcase
	end

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	assign w0 = alu_slot(issue_in.alu[0], st_q.rf, st_q.acc, vid); // [RULE5] [RULE13]
	// only the first ALU drives the video lanes; video ops on the second slot do nothing
	assign w1 = (issue_in.alu[1].op >= dsp_compute_pkg::ALU_ALIGN) ? '0
		: alu_slot(issue_in.alu[1], st_q.rf, st_q.acc, 32'h0);

	always_comb begin
		logic [39:0] an;
		logic [39:0] rv;
		logic [31:0] hv;
		logic [16:0] ea;
		logic [16:0] eb;
		an = 40'h0;
		rv = 40'h0;
		hv = 32'h0;
		ea = 17'h0;
		eb = 17'h0;
		st_d = st_q;
		st_d.rd = st_q.rf[rd_idx_in];
		for (int m = 0; m < 2; m++) begin
			// accumulate stage of each MAC
			an = st_q.acc[m];
			case (st_q.stg[m].op) // [RULE6]
				dsp_compute_pkg::MAC_MUL: an = {{7{st_q.prod[m][32]}}, st_q.prod[m]};
				dsp_compute_pkg::MAC_ACC: an = st_q.acc[m] + {{7{st_q.prod[m][32]}}, st_q.prod[m]};
				dsp_compute_pkg::MAC_SUB: an = st_q.acc[m] - {{7{st_q.prod[m][32]}}, st_q.prod[m]};
				dsp_compute_pkg::MAC_CLR: an = 40'h0;
				default:                  an = st_q.acc[m];
			endcase
			st_d.acc[m] = an;
			rv = st_q.stg[m].rnd ? an + `RND_BIAS : an; // [RULE7]
			hv = st_q.stg[m].sat ? sat32(rv) : rv[31:0]; // [RULE17]
			if (st_q.stg[m].op != dsp_compute_pkg::MAC_NONE && st_q.stg[m].wr) begin
				if (st_q.stg[m].dst[0]) st_d.rf[st_q.stg[m].dst[3:1]][31:16] = hv[31:16];
				else st_d.rf[st_q.stg[m].dst[3:1]][15:0] = hv[31:16];
			end
			st_d.stg[m].op = dsp_compute_pkg::MAC_NONE;
		end
		if (fire) begin
			for (int m = 0; m < 2; m++) begin
				if (issue_in.ld[m].en) begin // [RULE16]
					if (!issue_in.ld[m].half) st_d.rf[issue_in.ld[m].dst[3:1]] = issue_in.ld[m].data;
					else if (issue_in.ld[m].dst[0]) st_d.rf[issue_in.ld[m].dst[3:1]][31:16] = issue_in.ld[m].data[15:0];
					else st_d.rf[issue_in.ld[m].dst[3:1]][15:0] = issue_in.ld[m].data[15:0];
				end
			end
			for (int h = 0; h < 2; h++) begin // [RULE1]
				if (w0.mask[h]) st_d.rf[w0.idx][16*h+:16] = w0.val[16*h+:16];
				if (w1.mask[h]) st_d.rf[w1.idx][16*h+:16] = w1.val[16*h+:16];
			end
			if (issue_in.alu[0].op == dsp_compute_pkg::ALU_VSEARCH) begin // [RULE11]
				st_d.cc[1] = $signed(st_q.rf[issue_in.alu[0].b[3:1]][31:16]) > $signed(va[31:16]);
				st_d.cc[0] = $signed(st_q.rf[issue_in.alu[0].b[3:1]][15:0]) > $signed(va[15:0]);
			end
			if (issue_in.sh.op != dsp_compute_pkg::SH_NONE) st_d.rf[issue_in.sh.dst] = sh_res[31:0];
			for (int m = 0; m < 2; m++) begin
				// multiply stage: 17-bit extension covers both signed and unsigned
				ea = {1'b0, hget(st_q.rf, issue_in.mac[m].a)};
				ea[16] = issue_in.mac[m].sgn & ea[15];
				eb = {1'b0, hget(st_q.rf, issue_in.mac[m].b)};
				eb[16] = issue_in.mac[m].sgn & eb[15];
				st_d.prod[m] = $signed({{16{ea[16]}}, ea}) * $signed({{16{eb[16]}}, eb}); // [RULE6] [RULE7]
				st_d.stg[m] = issue_in.mac[m];
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) st_q <= '0;
		else st_q <= st_d;
	end

	assign rd_data_out = st_q.rd;
	assign acc0_out = st_q.acc[0];
	assign acc1_out = st_q.acc[1];
	assign cc_out = st_q.cc;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking dc @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	hazard_stalls_a: assert property ((st_q.stg[0].op != dsp_compute_pkg::MAC_NONE && st_q.stg[0].wr
		&& issue_in.alu[0].op != dsp_compute_pkg::ALU_NOP && issue_in.alu[0].a[3:1] == st_q.stg[0].dst[3:1])
		|-> !fire) // [RULE15]
		else $error("dependent issue not stalled");
	stall_bounded_a: assert property (!issue_ready_out |=> issue_ready_out) // [RULE15]
		else $error("stall longer than one cycle");
	mac_clear_a: assert property ((fire && issue_in.mac[0].op == dsp_compute_pkg::MAC_CLR)
		|=> ##1 acc0_out == 40'h0) // [RULE6]
		else $error("accumulator not cleared two cycles after issue");
	mac_accum_a: assert property ((st_q.stg[1].op == dsp_compute_pkg::MAC_ACC)
		|=> acc1_out == $past(acc1_out) + {{7{$past(st_q.prod[1][32])}}, $past(st_q.prod[1])}) // [RULE6]
		else $error("accumulate result wrong");
	add_clamp_a: assert property ((fire && issue_in.alu[0].op == dsp_compute_pkg::ALU_ADD && issue_in.alu[0].sat
		&& issue_in.alu[0].width == dsp_compute_pkg::W32 && !issue_in.alu[0].use_imm && !va[31] && !vb[31]
		&& w0.mask == 2'b11 && (va + vb) >= `SAT32_NEG) |-> w0.val == `SAT32_POS) // [RULE17]
		else $error("positive overflow not clamped");
	dual_halves_a: assert property ((fire && issue_in.alu[0].op == dsp_compute_pkg::ALU_ADD && !issue_in.alu[0].sat
		&& issue_in.alu[0].width == dsp_compute_pkg::DUAL && !issue_in.alu[0].use_imm)
		|-> w0.val == {16'(va[31:16] + vb[31:16]), 16'(va[15:0] + vb[15:0])}) // [RULE12]
		else $error("dual half add wrong");
	popcount_a: assert property ((fire && issue_in.alu[0].op == dsp_compute_pkg::ALU_POPCNT
		&& issue_in.alu[0].width == dsp_compute_pkg::W32) |-> w0.val == 32'($countones(va))) // [RULE9]
		else $error("population count wrong");
	mac_pending_a: assert property ((fire && issue_in.mac[0].op != dsp_compute_pkg::MAC_NONE && issue_in.mac[0].wr)
		|=> pend != 8'h00 ##1 pend == 8'h00 || st_q.stg[0].op != dsp_compute_pkg::MAC_NONE) // [RULE15]
		else $error("mac write not tracked");

endmodule

// *** include/dsp_compute_regs.svh ***
`ifndef DSP_COMPUTE_REGS_SVH
`define DSP_COMPUTE_REGS_SVH

// ---------------------------------------------
// datapath sizes and limits
// ---------------------------------------------
`define NUM_REGS  8
`define ACC_BITS  40
`define RND_BIAS  40'h00_0000_8000
`define SAT32_POS 32'h7fff_ffff
`define SAT32_NEG 32'h8000_0000
`define SAT16_POS 16'h7fff
`define SAT16_NEG 16'h8000
`define PIX_MAX   16'h00ff

`endif

// *** include/dsp_compute_pkg.sv ***
package dsp_compute_pkg;

	typedef logic [7:0][31:0] rf_t;

	typedef enum logic [4:0] {
		ALU_NOP, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_NOT, ALU_MIN, ALU_MAX,
		ALU_VSEARCH, ALU_EXTRACT, ALU_POPCNT, ALU_MUL32, ALU_DIVQ, ALU_SAT, ALU_RND,
		ALU_SIGNBITS, ALU_ALIGN, ALU_PACK, ALU_ADD16C, ALU_ADD8C, ALU_AVG8,
		ALU_SUBTRACT_ABSOLUTE_ACCUMULATE
	} alu_op_e;

	typedef enum logic [1:0] {W16, W32, DUAL} width_e;
	typedef enum logic [2:0] {MAC_NONE, MAC_MUL, MAC_ACC, MAC_SUB, MAC_CLR} mac_op_e;
	typedef enum logic [2:0] {SH_NONE, SH_LSL, SH_ASR, SH_LSR, SH_ROT, SH_NORM, SH_FEXT, SH_FDEP} sh_op_e;

	typedef struct packed {
		alu_op_e     op;
		width_e      width;
		logic [3:0]  a;
		logic [3:0]  b;
		logic        use_imm;
		logic [15:0] imm;
		logic        sat;
		logic [3:0]  dst;
	} alu_s;

	typedef struct packed {
		mac_op_e    op;
		logic [3:0] a;
		logic [3:0] b;
		logic       sgn;
		logic       rnd;
		logic       sat;
		logic       wr;
		logic [3:0] dst;
	} mac_s;

	typedef struct packed {
		sh_op_e     op;
		logic [2:0] src;
		logic       from_acc;
		logic [5:0] amt;
		logic [4:0] len;
		logic [2:0] dst;
	} sh_s;

	typedef struct packed {
		logic        en;
		logic        half;
		logic [3:0]  dst;
		logic [31:0] data;
	} ld_s;

	typedef struct packed {
		alu_s [1:0] alu;
		mac_s [1:0] mac;
		sh_s        sh;
		ld_s  [1:0] ld;
	} issue_s;

	typedef struct packed {
		logic [1:0]  mask;
		logic [2:0]  idx;
		logic [31:0] val;
	} wr_s;

	typedef struct packed {
		rf_t             rf;
		logic [1:0][39:0] acc;
		logic [1:0][32:0] prod;
		mac_s [1:0]      stg;
		logic [31:0]     rd;
		logic [1:0]      cc;
	} state_s;

endpackage

// *** testbench/issue_source.sv ***
`timescale 1ns/1ns

// -----------------------------------------
// issue side: holds each bundle until taken
// -----------------------------------------
module issue_source (
	input  wire logic               mclk_in,
	input  wire logic               ready_in,
	output logic                    valid_out,
	output dsp_compute_pkg::issue_s issue_out
);
	int unsigned             stall_n;
	dsp_compute_pkg::issue_s last_q;

	initial begin
		valid_out = 1'b0;
		issue_out = '0;
		last_q = '0;
		stall_n = 0;
	end

	task automatic send(input dsp_compute_pkg::issue_s b);
		@(negedge mclk_in);
		valid_out = 1'b1;
		issue_out = b;
		last_q = b;
		@(posedge mclk_in);
		while (ready_in !== 1'b1) begin
			stall_n++;
			@(posedge mclk_in);
		end
	endtask

	// released bundle shows the inverse, so stale operands never look live
	task automatic idle();
		@(negedge mclk_in);
		valid_out = 1'b0;
		issue_out = ~last_q;
	endtask
endmodule

// *** testbench/tb_dsp_compute_datapath.sv ***
`timescale 1ns/1ns
`include "dsp_compute_regs.svh"

module tb_dsp_compute_datapath;
	logic                    mclk_in;
	logic                    rst_b_in;
	logic                    issue_valid_in;
	dsp_compute_pkg::issue_s issue_in;
	logic [2:0]              rd_idx_in;
	logic                    issue_ready_out;
	logic [31:0]             rd_data_out;
	logic [39:0]             acc0_out;
	logic [39:0]             acc1_out;
	logic [1:0]              cc_out;
	int unsigned             n_mismatch;
	int unsigned             n_tests;
	int unsigned             cycle_n = 0;

	dsp_compute_datapath dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .issue_valid_in(issue_valid_in),
		.issue_in(issue_in), .rd_idx_in(rd_idx_in), .issue_ready_out(issue_ready_out),
		.rd_data_out(rd_data_out), .acc0_out(acc0_out), .acc1_out(acc1_out), .cc_out(cc_out));
	issue_source src_u (.mclk_in(mclk_in), .ready_in(issue_ready_out), .valid_out(issue_valid_in),
		.issue_out(issue_in));

	// -----------------------------------------
	// clock and hang guard
	// -----------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end

	// whole run needs well under a thousand cycles
	always @(posedge mclk_in) begin
		cycle_n++;
		if (cycle_n == 3000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// -----------------------------------------
	// shared tasks
	// -----------------------------------------
	task automatic finish_test();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// both 16-bit load slots in one bundle fill one register
	task automatic load_reg(input logic [2:0] r, input logic [31:0] v);
		dsp_compute_pkg::issue_s b;
		b = '0;
		b.ld[0] = '{1'b1, 1'b1, {r, 1'b1}, {16'h0000, v[31:16]}};
		b.ld[1] = '{1'b1, 1'b1, {r, 1'b0}, {16'h0000, v[15:0]}};
		src_u.send(b);
	endtask

	task automatic read_reg(input logic [2:0] r, input logic [31:0] exp);
		src_u.idle();
		rd_idx_in = r;
		@(negedge mclk_in);
		check({8'h00, rd_data_out}, {8'h00, exp});
	endtask

	task automatic alu_case(input dsp_compute_pkg::alu_op_e op, input dsp_compute_pkg::width_e w,
			input logic sat, input logic [31:0] va, input logic [31:0] vb, input logic [31:0] exp,
			input logic ui = 1'b0, input logic [15:0] imm = 16'h0000);
		dsp_compute_pkg::issue_s b;
		load_reg(3'h1, va);
		load_reg(3'h2, vb);
		load_reg(3'h3, 32'habcd_0100);
		b = '0;
		b.alu[0] = '{op, w, 4'h2, 4'h4, ui, imm, sat, 4'h6};
		src_u.send(b);
		read_reg(3'h3, exp);
	endtask

	task automatic sh_case(input dsp_compute_pkg::sh_op_e op, input logic [31:0] v, input logic [31:0] exp);
		dsp_compute_pkg::issue_s b;
		load_reg(3'h1, v);
		b = '0;
		b.sh = '{op, 3'h1, 1'b0, 6'h04, 5'h00, 3'h3};
		src_u.send(b);
		read_reg(3'h3, exp);
	endtask

	// -----------------------------------------
	// scenarios
	// -----------------------------------------
	task automatic dual_case();
		dsp_compute_pkg::issue_s b;
		load_reg(3'h1, 32'h0001_ffff);
		load_reg(3'h2, 32'h0001_0001);
		load_reg(3'h4, 32'h0005_0003);
		b = '0;
		b.alu[0] = '{dsp_compute_pkg::ALU_ADD, dsp_compute_pkg::DUAL, 4'h2, 4'h4, 1'b0, 16'h0000, 1'b0, 4'h6};
		b.alu[1] = '{dsp_compute_pkg::ALU_SUB, dsp_compute_pkg::DUAL, 4'h8, 4'h4, 1'b0, 16'h0000, 1'b0, 4'ha};
		src_u.send(b);
		read_reg(3'h3, 32'h0002_0000);
		read_reg(3'h5, 32'h0004_0002);
		b = '0;
		b.alu[0] = '{dsp_compute_pkg::ALU_VSEARCH, dsp_compute_pkg::DUAL, 4'h4, 4'h6, 1'b0, 16'h0000, 1'b0, 4'hc};
		src_u.send(b);
		src_u.idle();
		check({38'h0, cc_out}, 40'h2);
		read_reg(3'h6, 32'h0002_0001);
	endtask

	task automatic mac_case();
		dsp_compute_pkg::issue_s b;
		load_reg(3'h1, 32'hffff_fffe);
		load_reg(3'h2, 32'hffff_0003);
		b = '0;
		b.mac[0] = '{dsp_compute_pkg::MAC_MUL, 4'h2, 4'h4, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0};
		b.mac[1] = '{dsp_compute_pkg::MAC_MUL, 4'h3, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0};
		src_u.send(b);
		b.mac[0].op = dsp_compute_pkg::MAC_ACC;
		b.mac[1].op = dsp_compute_pkg::MAC_ACC;
		src_u.send(b);
		src_u.idle();
		repeat (2) @(negedge mclk_in);
		check(acc0_out, 40'hff_ffff_fff4);
		check(acc1_out, 40'h01_fffc_0002);
		b.mac[0].op = dsp_compute_pkg::MAC_CLR;
		b.mac[1].op = dsp_compute_pkg::MAC_SUB;
		src_u.send(b);
		src_u.idle();
		repeat (2) @(negedge mclk_in);
		check(acc0_out, 40'h00_0000_0000);
		check(acc1_out, 40'h00_fffe_0001);
	endtask

	// dependent add right behind a rounding multiply that writes its source
	task automatic stall_case();
		dsp_compute_pkg::issue_s b;
		int unsigned             s0;
		load_reg(3'h0, 32'h0000_0005);
		load_reg(3'h3, 32'h0080_0100);
		load_reg(3'h7, 32'h0000_0000);
		b = '0;
		b.mac[0] = '{dsp_compute_pkg::MAC_MUL, 4'h6, 4'h7, 1'b0, 1'b1, 1'b0, 1'b1, 4'hf};
		s0 = src_u.stall_n;
		src_u.send(b);
		b = '0;
		b.alu[0] = '{dsp_compute_pkg::ALU_ADD, dsp_compute_pkg::W32, 4'hf, 4'h0, 1'b0, 16'h0000, 1'b0, 4'h2};
		src_u.send(b);
		check(40'(src_u.stall_n - s0), 40'h1);
		read_reg(3'h1, 32'h0001_0005);
		read_reg(3'h7, 32'h0001_0000);
		check(acc0_out, 40'h00_0000_8000);
	endtask

	// -----------------------------------------
	// main sequence
	// -----------------------------------------
	initial begin
		n_mismatch = 0;
		n_tests = 0;
		rst_b_in = 1'b0;
		rd_idx_in = 3'h0;
		repeat (12) @(negedge mclk_in);
		check({39'h0, issue_ready_out}, 40'h1);
		check(acc0_out, 40'h0);
		rst_b_in = 1'b1;
		for (int r = 0; r < 8; r++) begin
			load_reg(3'(r), {8{3'(r), 1'b1}});
		end
		for (int r = 0; r < 8; r++) begin
			read_reg(3'(r), {8{3'(r), 1'b1}});
		end
		alu_case(dsp_compute_pkg::ALU_ADD, dsp_compute_pkg::W32, 1'b0,
			32'h1234_5678, 32'h1111_1111, 32'h2345_6789);
		alu_case(dsp_compute_pkg::ALU_SUB, dsp_compute_pkg::W32, 1'b0,
			32'h1234_5678, 32'h1111_1111, 32'h0123_4567);
		alu_case(dsp_compute_pkg::ALU_AND, dsp_compute_pkg::W32, 1'b0,
			32'hff00_ff00, 32'h0ff0_0ff0, 32'h0f00_0f00);
		alu_case(dsp_compute_pkg::ALU_XOR, dsp_compute_pkg::W32, 1'b0,
			32'hff00_ff00, 32'h0ff0_0ff0, 32'hf0f0_f0f0);
		alu_case(dsp_compute_pkg::ALU_ADD, dsp_compute_pkg::W32, 1'b0, 32'h10, 32'h0, 32'he, 1'b1, 16'hfffe);
		alu_case(dsp_compute_pkg::ALU_ADD, dsp_compute_pkg::W32, 1'b1, 32'h7fff_ffff, 32'h1, `SAT32_POS);
		alu_case(dsp_compute_pkg::ALU_SUB, dsp_compute_pkg::W32, 1'b1, 32'h8000_0000, 32'h1, `SAT32_NEG);
		alu_case(dsp_compute_pkg::ALU_ADD, dsp_compute_pkg::W16, 1'b0,
			32'h1111_0005, 32'h2222_0003, 32'habcd_0008);
		alu_case(dsp_compute_pkg::ALU_ADD, dsp_compute_pkg::W16, 1'b1, 32'h7fff, 32'h1, {16'habcd, `SAT16_POS});
		alu_case(dsp_compute_pkg::ALU_MUL32, dsp_compute_pkg::W32, 1'b0, 32'h1_0000, 32'h1_0001, 32'h1_0000);
		alu_case(dsp_compute_pkg::ALU_POPCNT, dsp_compute_pkg::W32, 1'b0, 32'hf0f0_0001, 32'h0, 32'h9);
		alu_case(dsp_compute_pkg::ALU_EXTRACT, dsp_compute_pkg::W32, 1'b0, 32'hab00, 32'h0808, 32'hab);
		alu_case(dsp_compute_pkg::ALU_MAX, dsp_compute_pkg::W32, 1'b0, 32'h5, 32'h9, 32'h9);
		alu_case(dsp_compute_pkg::ALU_MIN, dsp_compute_pkg::W32, 1'b0, 32'hffff_fffb, 32'h3, 32'hffff_fffb);
		alu_case(dsp_compute_pkg::ALU_DIVQ, dsp_compute_pkg::W32, 1'b0, 32'h0005_8000, 32'h3, 32'h0008_0001);
		alu_case(dsp_compute_pkg::ALU_SIGNBITS, dsp_compute_pkg::W32, 1'b0, 32'hffff_fff0, 32'h0, 32'h1b);
		alu_case(dsp_compute_pkg::ALU_PACK, dsp_compute_pkg::W32, 1'b0,
			32'h1122_3344, 32'h5566_7788, 32'h2244_6688);
		alu_case(dsp_compute_pkg::ALU_ALIGN, dsp_compute_pkg::W32, 1'b0,
			32'h1122_3344, 32'h5566_7788, 32'h4455_6677, 1'b0, 16'h0001);
		alu_case(dsp_compute_pkg::ALU_ADD16C, dsp_compute_pkg::W32, 1'b0,
			32'h0080_fff0, 32'h0090_0003, 32'h00ff_0000);
		alu_case(dsp_compute_pkg::ALU_ADD8C, dsp_compute_pkg::W32, 1'b0,
			32'hf010_8001, 32'h2010_8001, 32'hff20_ff02);
		alu_case(dsp_compute_pkg::ALU_AVG8, dsp_compute_pkg::W32, 1'b0,
			32'h1020_00fe, 32'h2040_00fe, 32'h1830_00fe);
		alu_case(dsp_compute_pkg::ALU_SUBTRACT_ABSOLUTE_ACCUMULATE, dsp_compute_pkg::W32, 1'b0,
			32'h1000_ff05, 32'h0010_0007, 32'habcd_0221);
		sh_case(dsp_compute_pkg::SH_LSL, 32'h0000_1234, 32'h0001_2340);
		sh_case(dsp_compute_pkg::SH_ASR, 32'h8000_0000, 32'hf800_0000);
		sh_case(dsp_compute_pkg::SH_ROT, 32'h8000_0001, 32'h0000_001f);
		sh_case(dsp_compute_pkg::SH_NORM, 32'h0000_1234, 32'h0000_0012);
		dual_case();
		mac_case();
		stall_case();
		finish_test();
	end
endmodule
